//--- hdl/iprb_pkg.sv
// Constants shared by the interrupt priority bank
package iprb_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int FIELD_W = 3;
    localparam int NUM_FIELDS = 17;

    // Register indexes on the plain register port
    localparam logic [4:0] REG_CAPTURE_3_TO_5 = 5'h09;
    localparam logic [4:0] REG_COMPARE_5_TO_7_CAPTURE_6 = 5'h0A;
    localparam logic [4:0] REG_PARALLEL_PORT_COMPARE_8 = 5'h0B;
    localparam logic [4:0] REG_SECOND_I2C_EVENTS = 5'h0C;
    localparam logic [4:0] REG_EXTERNAL_3_4 = 5'h0D;
    localparam logic [4:0] REG_CALENDAR_CLOCK = 5'h0F;
    localparam logic [4:0] REG_CRC_AND_UART_ERRORS = 5'h10;

    // Priority codes
    localparam logic [2:0] CODE_DISABLED = 3'h0;
    localparam logic [2:0] CODE_LOWEST = 3'h1;
    localparam logic [2:0] CODE_HIGHEST = 3'h7;
    localparam logic [2:0] CODE_RESET = 3'h4;

    // Field indexes
    localparam int F_CAPTURE3 = 0;
    localparam int F_CAPTURE4 = 1;
    localparam int F_CAPTURE5 = 2;
    localparam int F_CAPTURE6 = 3;
    localparam int F_COMPARE5 = 4;
    localparam int F_COMPARE6 = 5;
    localparam int F_COMPARE7 = 6;
    localparam int F_COMPARE8 = 7;
    localparam int F_PARALLEL = 8;
    localparam int F_I2C2_MASTER = 9;
    localparam int F_I2C2_SLAVE = 10;
    localparam int F_EXTERNAL3 = 11;
    localparam int F_EXTERNAL4 = 12;
    localparam int F_CALENDAR = 13;
    localparam int F_CHECKSUM = 14;
    localparam int F_UART1_ERR = 15;
    localparam int F_UART2_ERR = 16;

    // Register holding each field, by field index
    localparam logic [4:0] FIELD_REG [NUM_FIELDS] = '{
        REG_CAPTURE_3_TO_5, REG_CAPTURE_3_TO_5, REG_CAPTURE_3_TO_5,
        REG_COMPARE_5_TO_7_CAPTURE_6, REG_COMPARE_5_TO_7_CAPTURE_6,
        REG_COMPARE_5_TO_7_CAPTURE_6, REG_COMPARE_5_TO_7_CAPTURE_6,
        REG_PARALLEL_PORT_COMPARE_8, REG_PARALLEL_PORT_COMPARE_8,
        REG_SECOND_I2C_EVENTS, REG_SECOND_I2C_EVENTS,
        REG_EXTERNAL_3_4, REG_EXTERNAL_3_4,
        REG_CALENDAR_CLOCK,
        REG_CRC_AND_UART_ERRORS, REG_CRC_AND_UART_ERRORS, REG_CRC_AND_UART_ERRORS
    };

    // Lowest bit of each field, by field index
    localparam int FIELD_LSB [NUM_FIELDS] = '{
        4, 8, 12,
        0, 4, 8, 12,
        0, 4,
        8, 4,
        4, 8,
        8,
        12, 4, 8
    };
endpackage

//--- hdl/iprb_field.sv
// One software-writable priority field with its enable decode
`timescale 1ns/10ps
module iprb_field (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Write side
    input wire logic i_wr_en,
    input wire logic [2:0] i_wr_code,
    // Field state
    output logic [2:0] o_code,
    output logic o_enabled
);
    typedef struct packed {
        logic [2:0] code_reg;
        logic enabled_reg;
    } iprb_field_s;

    iprb_field_s state_reg;
    iprb_field_s state_next;

    always_comb begin
        state_next = state_reg;
        if (i_wr_en) begin
            state_next.code_reg = i_wr_code;
        end
        // Zero code keeps the source out of arbitration
        state_next.enabled_reg = (state_next.code_reg != iprb_pkg::CODE_DISABLED);
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg.code_reg <= iprb_pkg::CODE_RESET;
            state_reg.enabled_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_code = state_reg.code_reg;
    assign o_enabled = state_reg.enabled_reg;
endmodule

//--- hdl/iprb_bank.sv
// Interrupt priority bank: priority registers and their arbiter-facing fields
// Functional notes
// - code 111 means level 7, highest
// - code 001 is level 1; linear above
// - code 000 disables the source entirely
// - unassigned bits read zero, ignore writes
// - every field resets to code 100
// - fields read back the last written value
// - capture 5,4,3 at bits 14-12,10-8,6-4
// - compare 7,6,5 high; capture 6 at 2-0
// - parallel port 6-4, compare 8 2-0
// - i2c2 master 10-8, slave 6-4
// - external 4 at 10-8, 3 at 6-4
// - calendar clock only, at bits 10-8
// - checksum 14-12, uart2 10-8, uart1 6-4
`timescale 1ns/10ps
module iprb_bank #(
    parameter int ADDR_W = iprb_pkg::ADDR_W
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Register port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [iprb_pkg::DATA_W-1:0] i_wr_data,
    input wire logic i_wr_stb,
    input wire logic i_rd_stb,
    output logic [iprb_pkg::DATA_W-1:0] o_rd_data,
    // Priority levels to the arbiter
    output logic [2:0] o_capture3_priority,
    output logic [2:0] o_capture4_priority,
    output logic [2:0] o_capture5_priority,
    output logic [2:0] o_capture6_priority,
    output logic [2:0] o_compare5_priority,
    output logic [2:0] o_compare6_priority,
    output logic [2:0] o_compare7_priority,
    output logic [2:0] o_compare8_priority,
    output logic [2:0] o_parallel_port_priority,
    output logic [2:0] o_i2c2_master_priority,
    output logic [2:0] o_i2c2_slave_priority,
    output logic [2:0] o_external3_priority,
    output logic [2:0] o_external4_priority,
    output logic [2:0] o_calendar_clock_priority,
    output logic [2:0] o_checksum_error_priority,
    output logic [2:0] o_uart1_error_priority,
    output logic [2:0] o_uart2_error_priority,
    // Per-source enable, one bit per field index
    output logic [iprb_pkg::NUM_FIELDS-1:0] o_source_enabled
);
    localparam int NF = iprb_pkg::NUM_FIELDS;
    localparam int FW = iprb_pkg::FIELD_W;

    if (ADDR_W < 5) begin : g_addr_check
        $error("iprb_bank: ADDR_W must be at least 5");
    end

    typedef struct packed {
        logic [iprb_pkg::DATA_W-1:0] rd_data_reg;
    } iprb_bank_s;

    iprb_bank_s state_reg;
    iprb_bank_s state_next;

    logic [NF*FW-1:0] codes;
    logic [NF-1:0] enables;
    logic [4:0] reg_idx;
    logic addr_high_zero;

    // Addresses above the index range never alias a register
    assign reg_idx = i_addr[4:0];
    assign addr_high_zero = (ADDR_W == 5) ? 1'b1 : (i_addr >> 5) == '0;

    // Builds the read image of one register from the live field codes
    function automatic logic [iprb_pkg::DATA_W-1:0] reg_image(
        input logic [4:0] idx,
        input logic [NF*FW-1:0] fcodes
    );
        logic [iprb_pkg::DATA_W-1:0] img;
        img = '0;
        for (int f = 0; f < NF; f++) begin
            if (iprb_pkg::FIELD_REG[f] == idx) begin
                img[iprb_pkg::FIELD_LSB[f] +: FW] = fcodes[f*FW +: FW];
            end
        end
        return img;
    endfunction

    // Every field lane must fit inside the data word
    for (genvar g = 0; g < NF; g++) begin : g_lane_check
        if (iprb_pkg::FIELD_LSB[g] + FW > iprb_pkg::DATA_W) begin : g_bad_lane
            $error("iprb_bank: field lane outside the data word");
        end
    end

    // The arbiter ports carry three-bit codes
    if (FW != 3) begin : g_width_check
        $error("iprb_bank: priority fields must be three bits wide");
    end

    // One arbiter port and one enable bit per field
    if (NF != 17) begin : g_count_check
        $error("iprb_bank: field count does not match the ports");
    end

    // A write lands only on a mapped index with clean upper address bits
    function automatic logic write_selects(
        input logic stb,
        input logic high_zero,
        input logic [4:0] idx,
        input logic [4:0] reg_no
    );
        return stb && high_zero && (idx == reg_no);
    endfunction

    // Lanes outside every field are never taken from the write word
    function automatic logic [FW-1:0] write_lane(
        input logic [iprb_pkg::DATA_W-1:0] word,
        input int f
    );
        return word[iprb_pkg::FIELD_LSB[f] +: FW];
    endfunction

    // Write enables, one per register
    logic wr_capture_3_to_5;
    logic wr_compare_5_to_7_capture_6;
    logic wr_parallel_port_compare_8;
    logic wr_second_i2c_events;
    logic wr_external_3_4;
    logic wr_calendar_clock;
    logic wr_crc_and_uart_errors;

    assign wr_capture_3_to_5 = write_selects(i_wr_stb, addr_high_zero, reg_idx,
        iprb_pkg::REG_CAPTURE_3_TO_5);
    assign wr_compare_5_to_7_capture_6 = write_selects(i_wr_stb, addr_high_zero, reg_idx,
        iprb_pkg::REG_COMPARE_5_TO_7_CAPTURE_6);
    assign wr_parallel_port_compare_8 = write_selects(i_wr_stb, addr_high_zero, reg_idx,
        iprb_pkg::REG_PARALLEL_PORT_COMPARE_8);
    assign wr_second_i2c_events = write_selects(i_wr_stb, addr_high_zero, reg_idx,
        iprb_pkg::REG_SECOND_I2C_EVENTS);
    assign wr_external_3_4 = write_selects(i_wr_stb, addr_high_zero, reg_idx,
        iprb_pkg::REG_EXTERNAL_3_4);
    assign wr_calendar_clock = write_selects(i_wr_stb, addr_high_zero, reg_idx,
        iprb_pkg::REG_CALENDAR_CLOCK);
    assign wr_crc_and_uart_errors = write_selects(i_wr_stb, addr_high_zero, reg_idx,
        iprb_pkg::REG_CRC_AND_UART_ERRORS);

    // Capture channels 3 to 5 share one register
    iprb_field u_capture3 (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_wr_en(wr_capture_3_to_5),
        .i_wr_code(write_lane(i_wr_data, iprb_pkg::F_CAPTURE3)),
        .o_code(codes[iprb_pkg::F_CAPTURE3*FW +: FW]),
        .o_enabled(enables[iprb_pkg::F_CAPTURE3])
    );

    iprb_field u_capture4 (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_wr_en(wr_capture_3_to_5),
        .i_wr_code(write_lane(i_wr_data, iprb_pkg::F_CAPTURE4)),
        .o_code(codes[iprb_pkg::F_CAPTURE4*FW +: FW]),
        .o_enabled(enables[iprb_pkg::F_CAPTURE4])
    );

    iprb_field u_capture5 (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_wr_en(wr_capture_3_to_5),
        .i_wr_code(write_lane(i_wr_data, iprb_pkg::F_CAPTURE5)),
        .o_code(codes[iprb_pkg::F_CAPTURE5*FW +: FW]),
        .o_enabled(enables[iprb_pkg::F_CAPTURE5])
    );

    // Compare channels 5 to 7 and capture channel 6
    iprb_field u_capture6 (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_wr_en(wr_compare_5_to_7_capture_6),
        .i_wr_code(write_lane(i_wr_data, iprb_pkg::F_CAPTURE6)),
        .o_code(codes[iprb_pkg::F_CAPTURE6*FW +: FW]),
        .o_enabled(enables[iprb_pkg::F_CAPTURE6])
    );

    iprb_field u_compare5 (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_wr_en(wr_compare_5_to_7_capture_6),
        .i_wr_code(write_lane(i_wr_data, iprb_pkg::F_COMPARE5)),
        .o_code(codes[iprb_pkg::F_COMPARE5*FW +: FW]),
        .o_enabled(enables[iprb_pkg::F_COMPARE5])
    );

    iprb_field u_compare6 (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_wr_en(wr_compare_5_to_7_capture_6),
        .i_wr_code(write_lane(i_wr_data, iprb_pkg::F_COMPARE6)),
        .o_code(codes[iprb_pkg::F_COMPARE6*FW +: FW]),
        .o_enabled(enables[iprb_pkg::F_COMPARE6])
    );

    iprb_field u_compare7 (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_wr_en(wr_compare_5_to_7_capture_6),
        .i_wr_code(write_lane(i_wr_data, iprb_pkg::F_COMPARE7)),
        .o_code(codes[iprb_pkg::F_COMPARE7*FW +: FW]),
        .o_enabled(enables[iprb_pkg::F_COMPARE7])
    );

    // Parallel port and compare channel 8
    iprb_field u_compare8 (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_wr_en(wr_parallel_port_compare_8),
        .i_wr_code(write_lane(i_wr_data, iprb_pkg::F_COMPARE8)),
        .o_code(codes[iprb_pkg::F_COMPARE8*FW +: FW]),
        .o_enabled(enables[iprb_pkg::F_COMPARE8])
    );

    iprb_field u_parallel_port (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_wr_en(wr_parallel_port_compare_8),
        .i_wr_code(write_lane(i_wr_data, iprb_pkg::F_PARALLEL)),
        .o_code(codes[iprb_pkg::F_PARALLEL*FW +: FW]),
        .o_enabled(enables[iprb_pkg::F_PARALLEL])
    );

    // Second I2C module, master and slave events
    iprb_field u_i2c2_master (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_wr_en(wr_second_i2c_events),
        .i_wr_code(write_lane(i_wr_data, iprb_pkg::F_I2C2_MASTER)),
        .o_code(codes[iprb_pkg::F_I2C2_MASTER*FW +: FW]),
        .o_enabled(enables[iprb_pkg::F_I2C2_MASTER])
    );

    iprb_field u_i2c2_slave (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_wr_en(wr_second_i2c_events),
        .i_wr_code(write_lane(i_wr_data, iprb_pkg::F_I2C2_SLAVE)),
        .o_code(codes[iprb_pkg::F_I2C2_SLAVE*FW +: FW]),
        .o_enabled(enables[iprb_pkg::F_I2C2_SLAVE])
    );

    // External interrupts 3 and 4
    iprb_field u_external3 (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_wr_en(wr_external_3_4),
        .i_wr_code(write_lane(i_wr_data, iprb_pkg::F_EXTERNAL3)),
        .o_code(codes[iprb_pkg::F_EXTERNAL3*FW +: FW]),
        .o_enabled(enables[iprb_pkg::F_EXTERNAL3])
    );

    iprb_field u_external4 (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_wr_en(wr_external_3_4),
        .i_wr_code(write_lane(i_wr_data, iprb_pkg::F_EXTERNAL4)),
        .o_code(codes[iprb_pkg::F_EXTERNAL4*FW +: FW]),
        .o_enabled(enables[iprb_pkg::F_EXTERNAL4])
    );

    // Calendar clock, alone in its register
    iprb_field u_calendar_clock (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_wr_en(wr_calendar_clock),
        .i_wr_code(write_lane(i_wr_data, iprb_pkg::F_CALENDAR)),
        .o_code(codes[iprb_pkg::F_CALENDAR*FW +: FW]),
        .o_enabled(enables[iprb_pkg::F_CALENDAR])
    );

    // Checksum error and both UART error sources
    iprb_field u_checksum_error (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_wr_en(wr_crc_and_uart_errors),
        .i_wr_code(write_lane(i_wr_data, iprb_pkg::F_CHECKSUM)),
        .o_code(codes[iprb_pkg::F_CHECKSUM*FW +: FW]),
        .o_enabled(enables[iprb_pkg::F_CHECKSUM])
    );

    iprb_field u_uart1_error (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_wr_en(wr_crc_and_uart_errors),
        .i_wr_code(write_lane(i_wr_data, iprb_pkg::F_UART1_ERR)),
        .o_code(codes[iprb_pkg::F_UART1_ERR*FW +: FW]),
        .o_enabled(enables[iprb_pkg::F_UART1_ERR])
    );

    iprb_field u_uart2_error (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_wr_en(wr_crc_and_uart_errors),
        .i_wr_code(write_lane(i_wr_data, iprb_pkg::F_UART2_ERR)),
        .o_code(codes[iprb_pkg::F_UART2_ERR*FW +: FW]),
        .o_enabled(enables[iprb_pkg::F_UART2_ERR])
    );

    // Read data stand for one cycle after the strobe, zero otherwise
    always_comb begin
        state_next = state_reg;
        state_next.rd_data_reg = '0;
        if (i_rd_stb && addr_high_zero) begin
            state_next.rd_data_reg = reg_image(reg_idx, codes);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_rd_data = state_reg.rd_data_reg;

    // Codes pass straight through: 001..111 are levels 1..7, 000 is off
    assign o_capture3_priority = codes[iprb_pkg::F_CAPTURE3*FW +: FW];
    assign o_capture4_priority = codes[iprb_pkg::F_CAPTURE4*FW +: FW];
    assign o_capture5_priority = codes[iprb_pkg::F_CAPTURE5*FW +: FW];
    assign o_capture6_priority = codes[iprb_pkg::F_CAPTURE6*FW +: FW];
    assign o_compare5_priority = codes[iprb_pkg::F_COMPARE5*FW +: FW];
    assign o_compare6_priority = codes[iprb_pkg::F_COMPARE6*FW +: FW];
    assign o_compare7_priority = codes[iprb_pkg::F_COMPARE7*FW +: FW];
    assign o_compare8_priority = codes[iprb_pkg::F_COMPARE8*FW +: FW];
    assign o_parallel_port_priority = codes[iprb_pkg::F_PARALLEL*FW +: FW];
    assign o_i2c2_master_priority = codes[iprb_pkg::F_I2C2_MASTER*FW +: FW];
    assign o_i2c2_slave_priority = codes[iprb_pkg::F_I2C2_SLAVE*FW +: FW];
    assign o_external3_priority = codes[iprb_pkg::F_EXTERNAL3*FW +: FW];
    assign o_external4_priority = codes[iprb_pkg::F_EXTERNAL4*FW +: FW];
    assign o_calendar_clock_priority = codes[iprb_pkg::F_CALENDAR*FW +: FW];
    assign o_checksum_error_priority = codes[iprb_pkg::F_CHECKSUM*FW +: FW];
    assign o_uart1_error_priority = codes[iprb_pkg::F_UART1_ERR*FW +: FW];
    assign o_uart2_error_priority = codes[iprb_pkg::F_UART2_ERR*FW +: FW];
    assign o_source_enabled = enables;
endmodule

//--- verification/iprb_bank_props.sv
// Port assertions for the interrupt priority bank
`timescale 1ns/10ps
module iprb_bank_props #(
    parameter int ADDR_W = 5
) (
    // Clock, reset and register port
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [15:0] i_wr_data,
    input wire logic i_wr_stb,
    input wire logic i_rd_stb,
    input wire logic [15:0] o_rd_data,
    // Watched arbiter outputs
    input wire logic [2:0] o_capture5_priority,
    input wire logic [2:0] o_capture6_priority,
    input wire logic [2:0] o_compare8_priority,
    input wire logic [2:0] o_external3_priority,
    input wire logic [2:0] o_calendar_clock_priority,
    input wire logic [2:0] o_uart2_error_priority,
    input wire logic [16:0] o_source_enabled
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    sequence wr_at(a);
        i_wr_stb && i_addr == a;
    endsequence
    sequence rd_at(a);
        i_rd_stb && i_addr == a;
    endsequence
    rd_idle_a: assert property (!i_rd_stb |=> o_rd_data == 16'h0000)
        else $error("read data not idle");
    wr_capture5_a: assert property (wr_at(5'h09) |=> o_capture5_priority == $past(i_wr_data[14:12]))
        else $error("capture5 write");
    wr_capture6_a: assert property (wr_at(5'h0A) |=> o_capture6_priority == $past(i_wr_data[2:0]))
        else $error("capture6 write");
    rd_compare8_a: assert property (rd_at(5'h0B) |=> (o_rd_data & 16'hFF88) == 16'h0000
        && o_rd_data[2:0] == o_compare8_priority) else $error("compare8 read");
    wr_external3_a: assert property (wr_at(5'h0D) |=> o_external3_priority == $past(i_wr_data[6:4]))
        else $error("external3 write");
    rd_calendar_a: assert property (rd_at(5'h0F) |=> o_rd_data == {5'h00, o_calendar_clock_priority, 8'h00})
        else $error("calendar read");
    wr_uart2_a: assert property (wr_at(5'h10) |=> o_uart2_error_priority == $past(i_wr_data[10:8]))
        else $error("uart2 write");
    hold_value_a: assert property (!i_wr_stb |=> $stable(o_capture5_priority))
        else $error("priority changed without write");
    enable_code_a: assert property (o_source_enabled[3] == (o_capture6_priority != 3'h0))
        else $error("enable not matching code");
    reset_default_a: assert property ($rose(i_rst_n) |-> o_uart2_error_priority == 3'h4)
        else $error("reset default");
endmodule
bind iprb_bank iprb_bank_props #(.ADDR_W(ADDR_W)) u_props (.i_clk_sys, .i_rst_n, .i_addr,
    .i_wr_data, .i_wr_stb, .i_rd_stb, .o_rd_data, .o_capture5_priority, .o_capture6_priority,
    .o_compare8_priority, .o_external3_priority, .o_calendar_clock_priority,
    .o_uart2_error_priority, .o_source_enabled);

//--- verification/iprb_bank_bench.sv
// Self-checking bench for the interrupt priority bank
`timescale 1ns/10ps
module iprb_bank_bench;
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    logic [4:0] i_addr = 5'h00;
    logic [15:0] i_wr_data = 16'h0000;
    logic i_wr_stb = 1'b0;
    logic i_rd_stb = 1'b0;
    logic [15:0] o_rd_data;
    logic [2:0] p [17];
    logic [16:0] o_source_enabled;
    logic [15:0] mdl [32];
    logic rd_seen = 1'b0;
    logic [4:0] rd_a = 5'h00;
    logic [2:0] f;
    logic [4:0] ra [9] = '{5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0F, 5'h10, 5'h0E, 5'h1F};
    // Register and lowest bit of each field, in enable-vector order
    int fr [17] = '{9, 9, 9, 10, 10, 10, 10, 11, 11, 12, 12, 13, 13, 15, 16, 16, 16};
    int fl [17] = '{4, 8, 12, 0, 4, 8, 12, 0, 4, 8, 4, 4, 8, 8, 12, 4, 8};
    int n_mismatch = 0;
    int n_checks = 0;
    int k;
    int c;
    always #5 i_clk_sys = ~i_clk_sys;
    iprb_bank u_dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data),
        .o_capture3_priority(p[0]), .o_capture4_priority(p[1]), .o_capture5_priority(p[2]),
        .o_capture6_priority(p[3]), .o_compare5_priority(p[4]), .o_compare6_priority(p[5]),
        .o_compare7_priority(p[6]), .o_compare8_priority(p[7]), .o_parallel_port_priority(p[8]),
        .o_i2c2_master_priority(p[9]), .o_i2c2_slave_priority(p[10]),
        .o_external3_priority(p[11]), .o_external4_priority(p[12]),
        .o_calendar_clock_priority(p[13]), .o_checksum_error_priority(p[14]),
        .o_uart1_error_priority(p[15]), .o_uart2_error_priority(p[16]),
        .o_source_enabled(o_source_enabled));
    function automatic logic [15:0] msk(input logic [4:0] a);
        case (a)
            5'h09, 5'h10: return 16'h7770;
            5'h0A: return 16'h7777;
            5'h0B: return 16'h0077;
            5'h0C, 5'h0D: return 16'h0770;
            5'h0F: return 16'h0700;
            default: return 16'h0000;
        endcase
    endfunction
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Kind 0 idles, 1 writes, 2 reads; strobes are set once per cycle
    task automatic op(input int w, input logic [4:0] a, input logic [15:0] d);
        i_addr <= a;
        i_wr_data <= d;
        i_wr_stb <= w == 1;
        i_rd_stb <= w == 2;
        @(posedge i_clk_sys);
        if (w == 1) mdl[a] = d & msk(a);
    endtask
    task automatic report_and_stop;
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge i_clk_sys) begin
        rd_seen <= i_rd_stb;
        rd_a <= i_addr;
    end
    always @(negedge i_clk_sys) begin
        chk("read data", o_rd_data, rd_seen ? mdl[rd_a] : 16'h0000);
        for (int i = 0; i < 17; i++) begin
            f = mdl[fr[i]][fl[i] +: 3];
            chk("priority", {13'h0, p[i]}, {13'h0, f});
            chk("enable", {15'h0, o_source_enabled[i]}, {15'h0, f != 3'h0});
        end
    end
    initial begin
        c = $urandom(98);
        repeat (2) begin
            i_rst_n <= 1'b0;
            i_wr_stb <= 1'b0;
            i_rd_stb <= 1'b0;
            for (k = 0; k < 32; k++) begin
                mdl[k] = msk(5'(k)) & 16'h4444;
            end
            repeat (3) @(posedge i_clk_sys);
            i_rst_n <= 1'b1;
            for (c = 0; c < 8; c++) begin
                for (k = 0; k < 9; k++) begin
                    op(2, ra[k], 16'h0000);
                    op(1, ra[k], {4{1'b0, 3'(c)}});
                    op(2, ra[k], 16'h0000);
                end
            end
            for (k = 0; k < 300; k++) begin
                op($urandom_range(2), ra[$urandom_range(8)], 16'($urandom));
            end
            op(0, 5'h00, 16'h0000);
        end
        report_and_stop();
    end
    initial begin
        #50000;
        n_mismatch++;
        report_and_stop();
    end
endmodule
